// ==== design/ipr_consts.svh ====
// constant offsets, field positions, reset values and vectors of the prioritizer
`ifndef IPR_CONSTS_SVH
`define IPR_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define IPR_IDX_OPTION 6'h0c
`define IPR_IDX_SER_CTRL 6'h0f
`define IPR_IDX_SER_STAT 6'h10
`define IPR_IDX_TMR_CTRL 6'h12
`define IPR_IDX_TMR_STAT 6'h13
`define IPR_IDX_CORE_STAT 6'h14

// option register fields
`define IPR_OPT_POR 7
`define IPR_OPT_RISE 6
`define IPR_OPT_FALL 5
`define IPR_OPT_EXT_EN 4
`define IPR_OPT_WATCHDOG_ENABLE 0
// power-on value without the power-on flag: enable set, selects clear
`define IPR_OPT_RESET 8'h10

// timer control enables
`define IPR_TC_CAP_EN 7
`define IPR_TC_CMP_EN 6
`define IPR_TC_OVF_EN 5

// serial control two enables
`define IPR_SC_TXE_EN 7
`define IPR_SC_TXC_EN 6
`define IPR_SC_RX_EN 5
`define IPR_SC_IDLE_EN 4

// service vectors, high byte address; low byte sits one above
`define IPR_VEC_RESET 16'h1ffe
`define IPR_VEC_TRAP 16'h1ffc
`define IPR_VEC_EXT 16'h1ffa
`define IPR_VEC_CAP 16'h1ff8
`define IPR_VEC_CMP 16'h1ff6
`define IPR_VEC_OVF 16'h1ff4
`define IPR_VEC_SER 16'h1ff2

// bytes of processor state stacked per entry
`define IPR_STACK_BYTES 3'h5

`endif

// ==== design/ipr_pkg.sv ====
// types shared by the interrupt prioritizer files
package ipr_pkg;

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_RUN = 6'b00_0001,
        ST_PUSH = 6'b00_0010,
        ST_VEC_HI = 6'b00_0100,
        ST_VEC_LO = 6'b00_1000,
        ST_STOP = 6'b01_0000,
        ST_WAIT = 6'b10_0000
    } ipr_state_t;

    // source being serviced
    typedef enum logic [2:0] {
        SRC_RESET = 3'h0,
        SRC_TRAP = 3'h1,
        SRC_EXT = 3'h2,
        SRC_CAP = 3'h3,
        SRC_CMP = 3'h4,
        SRC_OVF = 3'h5,
        SRC_SER = 3'h6
    } ipr_src_t;

endpackage

// ==== design/ipr_ext_detect.sv ====
// external request pin: edge/level detection and pending latch
module ipr_ext_detect (
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset, high
    input wire logic ext_pin_n, // external request pin, active low
    input wire logic rising_edge_select, // sensitivity select, rising
    input wire logic falling_edge_select, // sensitivity select, falling
    input wire logic external_request_enable, // pin function enable
    input wire logic sel_change, // selection rewritten this cycle
    input wire logic req_ack, // service sequence took the request
    output logic ext_req // enabled request, latch or low level
);

    logic pin_prev_r; // pin one cycle ago
    logic latch_r; // pending edge latch
    logic latch_nxt; // next latch value
    wire rise_seen = ~pin_prev_r & ext_pin_n; // low to high
    wire fall_seen = pin_prev_r & ~ext_pin_n; // high to low
    wire level_mode = ~rising_edge_select & ~falling_edge_select;
    wire fall_on = ~rising_edge_select | falling_edge_select;
    // selected edge seen this cycle; a falling edge also counts in level mode
    wire edge_hit = (rise_seen & rising_edge_select) | (fall_seen & fall_on);
    // low level counts only in level mode and is not latched, but the falling edge into it is
    wire level_hit = level_mode & ~ext_pin_n; // (RULE9) (RULE14)

    // latch: a new edge wins over ack or selection change
    always_comb begin
        latch_nxt = latch_r;
        if (sel_change | req_ack) begin
            latch_nxt = 1'b0; // (RULE12) (RULE14)
        end
        if (edge_hit) begin
            latch_nxt = 1'b1; // (RULE13)
        end
    end

    // pin history and latch
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_prev_r <= 1'b1;
            latch_r <= 1'b0;
        end else begin
            pin_prev_r <= ext_pin_n;
            latch_r <= latch_nxt;
        end
    end

    // latched edge stays pending until enable returns
    assign ext_req = external_request_enable & (latch_r | level_hit); // (RULE6)

endmodule

// ==== design/ipr_top.sv ====
// interrupt prioritizer: arbitration, entry sequence and option registers
// Notes on behaviour
// (RULE1) grant highest pending source, others stay pending
// (RULE2) fixed priority order with fixed vector pairs
// (RULE3) software trap taken even when masked
// (RULE4) trap after older requests, before newer ones
// (RULE5) mask bit holds off every maskable request
// (RULE6) pin needs mask clear, enable, sensitivity match
// (RULE7) entry stacks state and sets mask bit
// (RULE8) option register field layout at its offset
// (RULE9) two select bits choose pin sensitivity
// (RULE10) select and enable writable only while masked
// (RULE11) reset clears selects, sets pin enable
// (RULE12) changing sensitivity discards pending pin request
// (RULE13) edge latched while disabled stays pending
// (RULE14) latch clears at entry; level never latched; a falling edge in level mode still sets the latch
// (RULE15) five timer flags, enabled ones raise requests
// (RULE16) three timer enables gate flag groups
// (RULE17) five serial flags share one vector
// (RULE18) four serial enables in control two
// (RULE19) serial flag clears: status read, data access
// (RULE20) reset fetches start vector, sets mask bit
// (RULE21) stop halts oscillator until pin request
// (RULE22) wait keeps timer; requests wake normally
// (RULE23) requests evaluated only at instruction boundary
// (RULE24) return restores mask from stacked copy
// (RULE25) each entry pushes five stack bytes
// (RULE26) granted source not preempted during fetch
`include "ipr_consts.svh"

module ipr_top (
    input wire logic mclk, // system clock, 200 MHz
    input wire logic rst, // synchronous reset, high
    input wire logic power_on_reset, // high when reset is power-on
    // avalon-mm slave
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    // external pin and peripherals
    input wire logic ext_pin_n, // external request pin
    input wire logic [4:0] timer_flags, // cap1 cap2 cmp1 cmp2 ovf
    input wire logic [4:0] serial_flags, // txe txc ovr rxf idle
    input wire logic serial_data_access, // serial data register access
    output logic [4:0] serial_flag_clear, // clear pulse per flag
    // processor core sequencer
    input wire logic insn_done, // instruction boundary pulse
    input wire logic trap_fetch, // trap opcode fetched pulse
    input wire logic mask_set_cmd, // set-mask instruction
    input wire logic mask_clear_cmd, // clear-mask instruction
    input wire logic return_cmd, // interrupt_return pulse
    input wire logic return_mask, // mask copy from the stack
    input wire logic stop_cmd, // stop instruction
    input wire logic wait_cmd, // wait instruction
    input wire logic vec_valid, // vector byte available
    input wire logic [7:0] vec_data, // vector byte
    output logic vec_rd, // vector byte request
    output logic [15:0] vec_addr, // vector byte address
    output logic stack_push, // push one state byte
    output logic pc_load, // load program counter pulse
    output logic [15:0] pc_value, // new program counter
    output logic core_hold, // core must not run
    output logic mask_bit, // condition_flags mask bit
    output logic osc_off, // oscillator stopped
    output logic core_clk_off // processor clocks stopped
);

    ipr_pkg::ipr_state_t state_r; // sequencer state
    ipr_pkg::ipr_state_t state_nxt; // next state
    ipr_pkg::ipr_src_t src_r; // source in service
    ipr_pkg::ipr_src_t grant_src; // winning source
    logic [7:0] option_r; // system_option_control
    logic por_r; // power-on flag
    logic [7:0] ser_ctrl_r; // serial_control_two
    logic [7:0] tmr_ctrl_r; // timer_control
    logic mask_r; // mask bit
    logic mask_nxt; // next mask bit
    logic trap_pend_r; // trap fetched, not yet taken
    logic [4:0] old_r; // requests pending at trap fetch
    logic [2:0] push_cnt_r; // bytes pushed so far
    logic [7:0] vec_hi_r; // captured high vector byte
    logic ack_r; // bus answer phase
    logic [4:0] ser_arm_r; // flags seen by a status read
    logic [31:0] rdata_r; // read data
    logic [15:0] pc_r; // program counter value
    logic pc_load_r; // load pulse
    logic grant; // entry starts this cycle
    logic ext_req; // recognised-but-unmasked pin request

    // bus decode
    wire [5:0] idx = avs_address[7:2]; // register index
    wire aligned = avs_address[1:0] == 2'b00; // word aligned
    wire req = avs_read | avs_write; // any request
    wire done = req & ack_r; // access completes
    wire wr_ok = done & avs_write & avs_byteenable[0]; // low lane write
    wire rd_ok = done & avs_read; // read completes
    wire hit_opt = aligned & (idx == `IPR_IDX_OPTION);
    wire hit_sc = aligned & (idx == `IPR_IDX_SER_CTRL);
    wire hit_ss = aligned & (idx == `IPR_IDX_SER_STAT);
    wire hit_tc = aligned & (idx == `IPR_IDX_TMR_CTRL);
    wire hit_ts = aligned & (idx == `IPR_IDX_TMR_STAT);
    wire hit_cs = aligned & (idx == `IPR_IDX_CORE_STAT);
    wire [7:0] wd = avs_writedata[7:0]; // write byte

    // option register write: guarded bits need the mask set
    wire opt_wr = wr_ok & hit_opt;
    wire guard_ok = opt_wr & mask_r; // (RULE10)
    wire [1:0] sel_new = {wd[`IPR_OPT_RISE], wd[`IPR_OPT_FALL]};
    wire [1:0] sel_old = {option_r[`IPR_OPT_RISE], option_r[`IPR_OPT_FALL]};
    wire sel_change = guard_ok & (sel_new != sel_old); // (RULE12)

    // grouped hardware requests, highest first
    wire cap_req = tmr_ctrl_r[`IPR_TC_CAP_EN] & |timer_flags[4:3]; // (RULE16)
    wire cmp_req = tmr_ctrl_r[`IPR_TC_CMP_EN] & |timer_flags[2:1]; // (RULE16)
    wire ovf_req = tmr_ctrl_r[`IPR_TC_OVF_EN] & timer_flags[0]; // (RULE15)
    wire ser_req = (ser_ctrl_r[`IPR_SC_TXE_EN] & serial_flags[4])
        | (ser_ctrl_r[`IPR_SC_TXC_EN] & serial_flags[3])
        | (ser_ctrl_r[`IPR_SC_RX_EN] & |serial_flags[2:1])
        | (ser_ctrl_r[`IPR_SC_IDLE_EN] & serial_flags[0]); // (RULE17) (RULE18)
    wire [4:0] hw_raw = {ext_req, cap_req, cmp_req, ovf_req, ser_req};
    wire [4:0] hw_req = mask_r ? 5'h00 : hw_raw; // (RULE5)
    wire [4:0] hw_old = hw_req & old_r; // pending before trap fetch
    wire take_old = trap_pend_r & |hw_old; // (RULE4)
    wire [4:0] pick = take_old ? hw_old : hw_req; // candidate set

    // highest set bit of the candidate set
    function automatic ipr_pkg::ipr_src_t top_src(input logic [4:0] r);
        ipr_pkg::ipr_src_t s;
        s = ipr_pkg::SRC_SER;
        if (r[1]) s = ipr_pkg::SRC_OVF;
        if (r[2]) s = ipr_pkg::SRC_CMP;
        if (r[3]) s = ipr_pkg::SRC_CAP;
        if (r[4]) s = ipr_pkg::SRC_EXT;
        return s;
    endfunction

    // vector address of a source
    function automatic logic [15:0] vec_of(input ipr_pkg::ipr_src_t s);
        logic [15:0] v;
        v = `IPR_VEC_RESET;
        unique case (s)
            ipr_pkg::SRC_RESET: v = `IPR_VEC_RESET;
            ipr_pkg::SRC_TRAP: v = `IPR_VEC_TRAP; // (RULE3)
            ipr_pkg::SRC_EXT: v = `IPR_VEC_EXT;
            ipr_pkg::SRC_CAP: v = `IPR_VEC_CAP;
            ipr_pkg::SRC_CMP: v = `IPR_VEC_CMP;
            ipr_pkg::SRC_OVF: v = `IPR_VEC_OVF;
            ipr_pkg::SRC_SER: v = `IPR_VEC_SER; // (RULE17)
            default: v = `IPR_VEC_RESET;
        endcase
        return v;
    endfunction

    // only at a boundary; trap goes ahead of newer hardware requests
    wire at_boundary = (state_r == ipr_pkg::ST_RUN) & insn_done; // (RULE23)
    wire trap_win = trap_pend_r & ~take_old; // (RULE3) (RULE4)
    wire hw_win = |pick; // (RULE1)
    wire wake_stop = (state_r == ipr_pkg::ST_STOP) & ext_req & ~mask_r;
    wire wake_wait = (state_r == ipr_pkg::ST_WAIT) & |hw_req;

    // grant decision and winning source
    always_comb begin
        grant = 1'b0;
        grant_src = ipr_pkg::SRC_SER;
        if (at_boundary & (trap_win | hw_win)) begin
            grant = 1'b1;
            grant_src = trap_win ? ipr_pkg::SRC_TRAP : top_src(pick); // (RULE2)
        end else if (wake_stop) begin
            grant = 1'b1; // (RULE21)
            grant_src = ipr_pkg::SRC_EXT;
        end else if (wake_wait) begin
            grant = 1'b1; // (RULE22)
            grant_src = top_src(hw_req);
        end
    end

    // pin latch clears as soon as its entry starts
    wire ext_ack = grant & (grant_src == ipr_pkg::SRC_EXT); // (RULE14)

    ipr_ext_detect u_ext (
        .mclk(mclk),
        .rst(rst),
        .ext_pin_n(ext_pin_n),
        .rising_edge_select(option_r[`IPR_OPT_RISE]),
        .falling_edge_select(option_r[`IPR_OPT_FALL]),
        .external_request_enable(option_r[`IPR_OPT_EXT_EN]),
        .sel_change(sel_change),
        .req_ack(ext_ack),
        .ext_req(ext_req)
    );

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ipr_pkg::ST_RUN: begin
                if (grant) begin
                    state_nxt = ipr_pkg::ST_PUSH; // (RULE7)
                end else if (at_boundary & stop_cmd) begin
                    state_nxt = ipr_pkg::ST_STOP;
                end else if (at_boundary & wait_cmd) begin
                    state_nxt = ipr_pkg::ST_WAIT;
                end
            end
            ipr_pkg::ST_PUSH: begin
                if (push_cnt_r == `IPR_STACK_BYTES - 3'h1) begin
                    state_nxt = ipr_pkg::ST_VEC_HI; // (RULE25)
                end
            end
            ipr_pkg::ST_VEC_HI: begin
                if (vec_valid) state_nxt = ipr_pkg::ST_VEC_LO;
            end
            ipr_pkg::ST_VEC_LO: begin
                if (vec_valid) state_nxt = ipr_pkg::ST_RUN;
            end
            ipr_pkg::ST_STOP, ipr_pkg::ST_WAIT: begin
                if (grant) state_nxt = ipr_pkg::ST_PUSH;
            end
        endcase
    end

    // mask bit next value; entry and reset win over software
    always_comb begin
        mask_nxt = mask_r;
        if (at_boundary & mask_clear_cmd) mask_nxt = 1'b0;
        if (at_boundary & mask_set_cmd) mask_nxt = 1'b1;
        if (at_boundary & return_cmd) mask_nxt = return_mask; // (RULE24)
        if (at_boundary & (stop_cmd | wait_cmd)) mask_nxt = 1'b0;
        if (grant) mask_nxt = 1'b1; // (RULE7)
    end

    // sequencer, service source and mask
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ipr_pkg::ST_VEC_HI; // (RULE20)
            src_r <= ipr_pkg::SRC_RESET;
            mask_r <= 1'b1; // (RULE20)
        end else begin
            state_r <= state_nxt;
            mask_r <= mask_nxt;
            if (grant) src_r <= grant_src; // (RULE26)
        end
    end

    // push counter and high vector byte
    always_ff @(posedge mclk) begin
        if (rst) begin
            push_cnt_r <= 3'h0;
            vec_hi_r <= 8'h00;
        end else begin
            push_cnt_r <= (state_r == ipr_pkg::ST_PUSH) ?
                push_cnt_r + 3'h1 : 3'h0;
            if ((state_r == ipr_pkg::ST_VEC_HI) & vec_valid) begin
                vec_hi_r <= vec_data;
            end
        end
    end

    // program counter load at the end of the vector fetch
    wire lo_done = (state_r == ipr_pkg::ST_VEC_LO) & vec_valid;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pc_r <= 16'h0000;
            pc_load_r <= 1'b0;
        end else begin
            pc_load_r <= lo_done;
            if (lo_done) pc_r <= {vec_hi_r, vec_data}; // (RULE2) (RULE20)
        end
    end

    // trap bookkeeping: note what was pending when it was fetched
    always_ff @(posedge mclk) begin
        if (rst) begin
            trap_pend_r <= 1'b0;
            old_r <= 5'h00;
        end else if (grant & (grant_src == ipr_pkg::SRC_TRAP)) begin
            trap_pend_r <= 1'b0;
            old_r <= 5'h00;
        end else if (trap_fetch) begin
            trap_pend_r <= 1'b1;
            old_r <= hw_req; // (RULE4)
        end
    end

    // option register; reset value sets the pin enable
    always_ff @(posedge mclk) begin
        if (rst) begin
            option_r <= `IPR_OPT_RESET; // (RULE11)
            por_r <= 1'b0;
        end else begin
            if (opt_wr) begin
                option_r[3:1] <= wd[3:1]; // (RULE8)
                if (wd[`IPR_OPT_WATCHDOG_ENABLE]) option_r[`IPR_OPT_WATCHDOG_ENABLE] <= 1'b1;
            end
            if (guard_ok) option_r[6:4] <= wd[6:4]; // (RULE10)
        end
        if (rst) por_r <= power_on_reset; // flag taken while reset holds
    end

    // peripheral enable registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ser_ctrl_r <= 8'h00;
            tmr_ctrl_r <= 8'h00;
        end else begin
            if (wr_ok & hit_sc) ser_ctrl_r <= wd; // (RULE18)
            if (wr_ok & hit_tc) tmr_ctrl_r <= wd; // (RULE16)
        end
    end

    // serial flag clear: arm on status read, fire on data access
    always_ff @(posedge mclk) begin
        if (rst) begin
            ser_arm_r <= 5'h00;
        end else if (serial_data_access) begin
            ser_arm_r <= 5'h00;
        end else if (rd_ok & hit_ss) begin
            ser_arm_r <= serial_flags; // (RULE19)
        end
    end
    assign serial_flag_clear = serial_data_access ? ser_arm_r : 5'h00; // (RULE19)

    // read multiplexer
    wire [7:0] opt_rd = {por_r, option_r[6:0]}; // (RULE8)
    wire [7:0] core_rd = {core_clk_off, trap_pend_r, hw_raw, mask_r};
    wire [7:0] rd_byte = hit_opt ? opt_rd
        : hit_sc ? ser_ctrl_r
        : hit_ss ? {serial_flags, 3'b000}
        : hit_tc ? tmr_ctrl_r
        : hit_ts ? {timer_flags, 3'b000} // (RULE15)
        : hit_cs ? core_rd
        : 8'h00;

    // bus answer: one wait state, read data captured in it
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            if (avs_read & ~ack_r) rdata_r <= {24'h00_0000, rd_byte};
        end
    end

    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata = rdata_r;
    assign vec_rd = (state_r == ipr_pkg::ST_VEC_HI)
        | (state_r == ipr_pkg::ST_VEC_LO);
    assign vec_addr = (state_r == ipr_pkg::ST_VEC_LO) ?
        vec_of(src_r) + 16'h0001 : vec_of(src_r);
    assign stack_push = state_r == ipr_pkg::ST_PUSH; // (RULE25)
    assign pc_load = pc_load_r;
    assign pc_value = pc_r;
    assign core_hold = state_r != ipr_pkg::ST_RUN;
    assign mask_bit = mask_r;
    assign osc_off = state_r == ipr_pkg::ST_STOP; // (RULE21)
    assign core_clk_off = (state_r == ipr_pkg::ST_STOP)
        | (state_r == ipr_pkg::ST_WAIT); // (RULE22)

endmodule

// ==== testbench/ipr_props.sv ====
// concurrent checks on the prioritizer ports
module ipr_props (
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic insn_done, // boundary pulse
    input wire logic vec_valid, // vector byte answer
    input wire logic vec_rd, // vector byte request
    input wire logic [15:0] vec_addr, // vector byte address
    input wire logic stack_push, // state byte push
    input wire logic pc_load, // counter load pulse
    input wire logic core_hold, // core halted
    input wire logic mask_bit, // global mask
    input wire logic osc_off, // oscillator stopped
    input wire logic core_clk_off, // core clocks stopped
    input wire logic [4:0] serial_flags, // serial flag levels
    input wire logic serial_data_access, // data register access
    input wire logic [4:0] serial_flag_clear // flag clear pulses
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // entry pushes exactly five bytes
    property p_push_five;
        $rose(stack_push) |-> stack_push[*5] ##1 !stack_push;
    endproperty
    a_push_five: assert property (p_push_five)
        else $error("stack push run not five cycles");
    // entry happens with mask set and core held
    property p_mask_entry;
        $rose(stack_push) |-> mask_bit && core_hold;
    endproperty
    a_mask_entry: assert property (p_mask_entry)
        else $error("entry without mask set");
    // low byte address follows the high byte
    property p_vec_pair;
        vec_rd && vec_valid && !vec_addr[0]
            |=> vec_rd && vec_addr == $past(vec_addr) + 16'h0001;
    endproperty
    a_vec_pair: assert property (p_vec_pair)
        else $error("vector low byte not next address");
    // second byte answered, counter loaded next cycle
    property p_pc_load;
        vec_rd && vec_valid && vec_addr[0] |=> pc_load && !core_hold;
    endproperty
    a_pc_load: assert property (p_pc_load)
        else $error("counter not loaded after vector");
    // running core leaves run only at a boundary
    property p_boundary;
        !core_hold && !insn_done |=> !core_hold;
    endproperty
    a_boundary: assert property (p_boundary)
        else $error("core held between boundaries");
    // stop also stops core clocks and holds core
    property p_stop_clk;
        osc_off |-> core_clk_off && core_hold;
    endproperty
    a_stop_clk: assert property (p_stop_clk)
        else $error("stop without core clocks off");
    // clear pulses only for set flags on data access
    property p_ser_clear;
        |serial_flag_clear
            |-> serial_data_access && !(serial_flag_clear & ~serial_flags);
    endproperty
    a_ser_clear: assert property (p_ser_clear)
        else $error("serial clear without cause");
    // reset leaves mask set and start vector requested
    property p_rst_vec;
        $fell(rst) |-> mask_bit && vec_rd && vec_addr == 16'h1ffe;
    endproperty
    a_rst_vec: assert property (p_rst_vec)
        else $error("reset vector fetch wrong");
    c_push: cover property ($rose(stack_push));
    c_load: cover property (pc_load);
    c_stop: cover property ($rose(osc_off));
endmodule

bind ipr_top ipr_props u_props (.*);

// ==== testbench/ipr_core_model.sv ====
// core-side partner: answers vector byte reads, prompt or slow
module ipr_core_model (
    input wire logic mclk, // system clock
    input wire logic rst, // reset, high
    input wire logic slow, // stretch each answer
    input wire logic vec_rd, // vector byte request
    input wire logic [15:0] vec_addr, // byte address
    output logic vec_valid, // byte available
    output logic [7:0] vec_data // byte value
);
    logic [1:0] wait_r; // cycles held so far
    // table bytes derive from address; garbage when not answering
    assign vec_valid = vec_rd && (!slow || wait_r == 2'h3);
    assign vec_data = vec_valid ? vec_addr[7:0] ^ 8'ha5
                                : ~(vec_addr[7:0] ^ 8'ha5);
    // count the hold of one request, restart on answer
    always_ff @(posedge mclk) begin
        if (rst || !vec_rd || vec_valid) begin
            wait_r <= 2'h0;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
// bench: reset, vectoring, masking, serial clear, stop wake
`define TB_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    error_cnt++; $display("[FAIL] %0t got %h want %h", $time, a, b); \
    end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, power_on_reset, avs_read, avs_write, ext_pin_n;
    logic [7:0] avs_address, vec_data;
    logic [31:0] avs_writedata, avs_readdata, rd_q;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, serial_data_access, insn_done, trap_fetch;
    logic mask_set_cmd, mask_clear_cmd, return_cmd, return_mask, stop_cmd;
    logic wait_cmd, vec_valid, vec_rd, stack_push, pc_load, core_hold;
    logic mask_bit, osc_off, core_clk_off, slow;
    logic [4:0] timer_flags, serial_flags, serial_flag_clear;
    logic [15:0] vec_addr, pc_value;
    int error_cnt, tests_run;
    ipr_top uut (.*);
    ipr_core_model u_core (.*);
    always #2.5 mclk = ~mclk; // 200 MHz
    task automatic conclude();
        $display("compares %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic tmo();
        error_cnt++;
        $display("[FAIL] %0t wait ran out", $time);
        conclude();
    endtask
    // one bus access; held until waitrequest low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (avs_waitrequest && n < 20);
        if (n >= 20) tmo();
        @(posedge mclk);
        rd_q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // one boundary, c = {clear mask, return, stop}
    task automatic ins(input logic [2:0] c);
        @(posedge mclk);
        insn_done <= 1'b1;
        {mask_clear_cmd, return_cmd, stop_cmd} <= c;
        @(posedge mclk);
        insn_done <= 1'b0;
        {mask_clear_cmd, return_cmd, stop_cmd} <= 3'h0;
    endtask
    // follow one entry and judge its vector and loaded counter
    task automatic entry(input logic [15:0] v);
        int n;
        logic [15:0] got;
        n = 0;
        #1;
        while (vec_rd !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1;
            n++;
        end
        got = vec_addr;
        while (pc_load !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 100) tmo();
        `TB_CHK(got, v)
        `TB_CHK(pc_value, {v[7:0] ^ 8'ha5, (v[7:0] + 8'h01) ^ 8'ha5})
        `TB_CHK(mask_bit, 1'b1)
        @(posedge mclk);
    endtask
    // reset vector, option reset value and masked writes
    task automatic t_reset();
        entry(16'h1ffe);
        bus(1'b0, 8'h30, 8'h00);
        `TB_CHK(rd_q[7:0], 8'h90)
        bus(1'b1, 8'h30, 8'h70);
        bus(1'b0, 8'h30, 8'h00);
        `TB_CHK(rd_q[7:0], 8'hf0)
        bus(1'b1, 8'h30, 8'h10);
    endtask
    // pin and capture both pending; mask and priority order
    task automatic t_prio();
        timer_flags <= 5'b10000;
        ext_pin_n <= 1'b0;
        bus(1'b1, 8'h48, 8'h80);
        ins(3'h0);
        @(posedge mclk);
        #1;
        `TB_CHK(core_hold, 1'b0)
        ins(3'h4);
        bus(1'b1, 8'h30, 8'h00);
        bus(1'b0, 8'h30, 8'h00);
        `TB_CHK(rd_q[7:0], 8'h90)
        ins(3'h0);
        entry(16'h1ffa);
        ext_pin_n <= 1'b1;
        ins(3'h2);
        ins(3'h0);
        entry(16'h1ff8);
        timer_flags <= 5'b00000;
    endtask
    // trap taken while masked, slow vector answers
    task automatic t_trap();
        slow <= 1'b1;
        @(posedge mclk);
        trap_fetch <= 1'b1;
        @(posedge mclk);
        trap_fetch <= 1'b0;
        ins(3'h0);
        entry(16'h1ffc);
        slow <= 1'b0;
    endtask
    // serial request, status read then data access clears
    task automatic t_ser();
        serial_flags <= 5'b00010;
        bus(1'b1, 8'h3c, 8'h20);
        ins(3'h2);
        ins(3'h0);
        entry(16'h1ff2);
        bus(1'b0, 8'h40, 8'h00);
        `TB_CHK(rd_q[7:3], 5'b00010)
        @(posedge mclk);
        serial_data_access <= 1'b1;
        #1;
        `TB_CHK(serial_flag_clear, 5'b00010)
        @(posedge mclk);
        serial_data_access <= 1'b0;
        serial_flags <= 5'b00000;
    endtask
    // stop ignores timer, wakes on pin
    task automatic t_stop();
        ins(3'h2);
        ins(3'h1);
        timer_flags <= 5'b10000;
        repeat (6) @(posedge mclk);
        #1;
        `TB_CHK(osc_off, 1'b1)
        @(posedge mclk);
        timer_flags <= 5'b00000;
        ext_pin_n <= 1'b0;
        entry(16'h1ffa);
        ext_pin_n <= 1'b1;
    endtask
    // time-zero values, reset, then the scenarios
    initial begin
        {mclk, avs_read, avs_write, serial_data_access, insn_done} = '0;
        {trap_fetch, mask_set_cmd, mask_clear_cmd, return_cmd} = '0;
        {return_mask, stop_cmd, wait_cmd, slow, error_cnt, tests_run} = '0;
        {avs_address, avs_writedata, timer_flags, serial_flags} = '0;
        {rst, power_on_reset, ext_pin_n} = 3'h7;
        avs_byteenable = 4'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_prio();
        t_trap();
        t_ser();
        t_stop();
        conclude();
    end
endmodule
